/* hw/cltov_regs.svh */
// Purpose: register offsets, field positions and reset values of the clock-lane timing override bank
// Assumes: byte-wide registers on a plain address/strobe port
// Notes: definitions only, no logic
`ifndef CLTOV_REGS_SVH
`define CLTOV_REGS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define CLTOV_ADDR_W 8
`define CLTOV_OFS_RATE_SEL 8'h30
`define CLTOV_OFS_SEQ_STATUS 8'h31
`define CLTOV_OFS_CLK_PREPARE 8'h40
`define CLTOV_OFS_CLK_ZERO 8'h41

// ***************************************************************
// field positions
// ***************************************************************
`define CLTOV_OVR_BIT 7
`define CLTOV_VAL_MSB 6
`define CLTOV_VAL_W 7
`define CLTOV_RATE_MSB 2

// ***************************************************************
// reset values, auto timing at the 800 Mbps lane rate
// ***************************************************************
`define CLTOV_RST_CLK_PREPARE 7'h05
`define CLTOV_RST_CLK_ZERO 7'h1b
`define CLTOV_RST_RATE 3'h1
`define CLTOV_UNMAPPED_RDATA 8'h00

// ***************************************************************
// timing counts
// ***************************************************************
`define CLTOV_MIN_PHASE_CYC 7'h01

`endif

/* hw/cltov_pkg.sv */
// Purpose: types shared by the clock-lane timing override bank
// Assumes: nothing beyond the register header
// Notes: rate codes and sequencer states
`default_nettype none

package cltov_pkg;

    // lane rate selection codes
    typedef enum logic [2:0] {
        CLTOV_RATE_400 = 3'b000,
        CLTOV_RATE_800 = 3'b001,
        CLTOV_RATE_1200 = 3'b010,
        CLTOV_RATE_1500 = 3'b011,
        CLTOV_RATE_1600 = 3'b100
    } cltov_rate_t;

    // clock-lane start-up sequencer
    typedef enum logic [1:0] {
        CLTOV_SEQ_STOP = 2'b00,
        CLTOV_SEQ_PREPARE = 2'b01,
        CLTOV_SEQ_ZERO = 2'b10,
        CLTOV_SEQ_HS = 2'b11
    } cltov_seq_t;

endpackage

`default_nettype wire

/* hw/cltov_field.sv */
// Purpose: one override bit plus 7-bit timing value with auto tracking
// Assumes: wr_en is a one-cycle strobe already decoded for this register
// Notes: value_r is what the lane logic applies and what software reads
`include "cltov_regs.svh"
`default_nettype none

module cltov_field #(
    parameter logic [6:0] RESET_VAL = 7'h00
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic [6:0] auto_val,
    output logic override_r,
    output logic [6:0] value_r
);

    // ***************************************************************
    // next-state decode
    // ***************************************************************
    // a write that sets the override loads its value in the same cycle
    wire logic override_nxt;
    wire logic [6:0] value_nxt;
    assign override_nxt = wr_en ? wr_data[`CLTOV_OVR_BIT] : override_r;
    assign value_nxt = override_nxt ? (wr_en ? wr_data[`CLTOV_VAL_MSB:0] : value_r) : auto_val;

    // ***************************************************************
    // storage
    // ***************************************************************
    // with override clear the field follows the auto value, writes to it are lost
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            override_r <= 1'b0;
            value_r <= RESET_VAL;
        end else begin
            override_r <= override_nxt;
            value_r <= value_nxt;
        end
    end

endmodule

`default_nettype wire

/* hw/cltov_top.sv */
// Purpose: clock-lane prepare/zero timing override bank with a start-up sequencer
// Assumes: single clock sys_clk, synchronous active-low resetn, strobes one cycle long
// Notes: sequencer counts in byte-clock cycles, one sys_clk cycle per byte clock
//
// Summary of operation
// - prepare override bit clear means prepare time is chosen automatically.
// - prepare override bit set means low seven bits give the prepare time.
// - zero time has its own override bit with the same auto/manual choice.
// - override clear: value field ignores writes and reads the current auto value.
// - override set: value field takes writes and reads back the stored value.
// - after reset auto values are 0x05 prepare and 0x1b zero, the 800 Mbps set.
// - a new lane rate with override off updates the auto values.
`include "cltov_regs.svh"
`default_nettype none

module cltov_top
    import cltov_pkg::*;
#(
    parameter logic [6:0] PREP_400 = 7'h03,
    parameter logic [6:0] ZERO_400 = 7'h0e,
    parameter logic [6:0] PREP_1200 = 7'h07,
    parameter logic [6:0] ZERO_1200 = 7'h28,
    parameter logic [6:0] PREP_1500 = 7'h09,
    parameter logic [6:0] ZERO_1500 = 7'h32,
    parameter logic [6:0] PREP_1600 = 7'h09,
    parameter logic [6:0] ZERO_1600 = 7'h36
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic hs_clk_req,
    output logic [1:0] lane_state,
    output logic hs_clk_active,
    output logic [6:0] clk_prepare_cycles,
    output logic [6:0] clk_zero_cycles
);

    // ***************************************************************
    // address decode
    // ***************************************************************
    wire logic hit_rate;
    wire logic hit_status;
    wire logic hit_prepare;
    wire logic hit_zero;
    assign hit_rate = (reg_addr == `CLTOV_OFS_RATE_SEL);
    assign hit_status = (reg_addr == `CLTOV_OFS_SEQ_STATUS);
    assign hit_prepare = (reg_addr == `CLTOV_OFS_CLK_PREPARE);
    assign hit_zero = (reg_addr == `CLTOV_OFS_CLK_ZERO);

    wire logic wr_rate;
    wire logic wr_prepare;
    wire logic wr_zero;
    assign wr_rate = reg_wr && hit_rate;
    assign wr_prepare = reg_wr && hit_prepare;
    assign wr_zero = reg_wr && hit_zero;

    // ***************************************************************
    // lane rate selection
    // ***************************************************************
    // undefined codes are dropped so the lookup never sees them
    cltov_rate_t rate_r;
    cltov_rate_t rate_nxt;
    wire logic rate_code_ok;
    assign rate_code_ok = (reg_wdata[`CLTOV_RATE_MSB:0] <= 3'h4);
    assign rate_nxt = (wr_rate && rate_code_ok) ? cltov_rate_t'(reg_wdata[`CLTOV_RATE_MSB:0]) : rate_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rate_r <= cltov_rate_t'(`CLTOV_RST_RATE);
        end else begin
            rate_r <= rate_nxt;
        end
    end

    // ***************************************************************
    // automatic timing lookup
    // ***************************************************************
    // registered so a rate change reaches the fields two cycles after the write
    logic [6:0] auto_prepare_r;
    logic [6:0] auto_zero_r;
    wire logic [6:0] auto_prepare_nxt;
    wire logic [6:0] auto_zero_nxt;
    assign auto_prepare_nxt = (rate_r == CLTOV_RATE_400) ? PREP_400 :
                              (rate_r == CLTOV_RATE_1200) ? PREP_1200 :
                              (rate_r == CLTOV_RATE_1500) ? PREP_1500 :
                              (rate_r == CLTOV_RATE_1600) ? PREP_1600 :
                              `CLTOV_RST_CLK_PREPARE;
    assign auto_zero_nxt = (rate_r == CLTOV_RATE_400) ? ZERO_400 :
                           (rate_r == CLTOV_RATE_1200) ? ZERO_1200 :
                           (rate_r == CLTOV_RATE_1500) ? ZERO_1500 :
                           (rate_r == CLTOV_RATE_1600) ? ZERO_1600 :
                           `CLTOV_RST_CLK_ZERO;

    // reset lands on the 800 Mbps set
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            auto_prepare_r <= `CLTOV_RST_CLK_PREPARE;
            auto_zero_r <= `CLTOV_RST_CLK_ZERO;
        end else begin
            auto_prepare_r <= auto_prepare_nxt;
            auto_zero_r <= auto_zero_nxt;
        end
    end

    // ***************************************************************
    // override fields
    // ***************************************************************
    // auto tracking and write gating live in the field module
    logic clk_prepare_override;
    logic [6:0] clk_prepare_value;
    logic clk_zero_override;
    logic [6:0] clk_zero_value;

    cltov_field #(
        .RESET_VAL(`CLTOV_RST_CLK_PREPARE)
    ) u_prepare (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wr_en(wr_prepare),
        .wr_data(reg_wdata),
        .auto_val(auto_prepare_r),
        .override_r(clk_prepare_override),
        .value_r(clk_prepare_value)
    );

    cltov_field #(
        .RESET_VAL(`CLTOV_RST_CLK_ZERO)
    ) u_zero (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wr_en(wr_zero),
        .wr_data(reg_wdata),
        .auto_val(auto_zero_r),
        .override_r(clk_zero_override),
        .value_r(clk_zero_value)
    );

    assign clk_prepare_cycles = clk_prepare_value;
    assign clk_zero_cycles = clk_zero_value;

    // ***************************************************************
    // clock-lane start-up sequencer
    // ***************************************************************
    // a zero value still gives one cycle, the lane never skips a phase
    cltov_seq_t seq_r;
    cltov_seq_t seq_nxt;
    logic [6:0] phase_cnt_r;
    logic [6:0] phase_cnt_nxt;
    wire logic [6:0] load_prepare;
    wire logic [6:0] load_zero;
    wire logic phase_done;
    assign load_prepare = (clk_prepare_value == 7'h00) ? `CLTOV_MIN_PHASE_CYC : clk_prepare_value;
    assign load_zero = (clk_zero_value == 7'h00) ? `CLTOV_MIN_PHASE_CYC : clk_zero_value;
    assign phase_done = (phase_cnt_r <= `CLTOV_MIN_PHASE_CYC);

    // dropping the request aborts to stop from any phase
    always_comb begin
        seq_nxt = seq_r;
        phase_cnt_nxt = phase_cnt_r;
        if (!hs_clk_req) begin
            seq_nxt = CLTOV_SEQ_STOP;
            phase_cnt_nxt = 7'h00;
        end else begin
            case (seq_r)
                CLTOV_SEQ_STOP: begin
                    seq_nxt = CLTOV_SEQ_PREPARE;
                    phase_cnt_nxt = load_prepare;
                end
                CLTOV_SEQ_PREPARE: begin
                    if (phase_done) begin
                        seq_nxt = CLTOV_SEQ_ZERO;
                        phase_cnt_nxt = load_zero;
                    end else begin
                        phase_cnt_nxt = phase_cnt_r - 7'h01;
                    end
                end
                CLTOV_SEQ_ZERO: begin
                    if (phase_done) begin
                        seq_nxt = CLTOV_SEQ_HS;
                        phase_cnt_nxt = 7'h00;
                    end else begin
                        phase_cnt_nxt = phase_cnt_r - 7'h01;
                    end
                end
                default: begin
                    seq_nxt = CLTOV_SEQ_HS;
                    phase_cnt_nxt = 7'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            seq_r <= CLTOV_SEQ_STOP;
            phase_cnt_r <= 7'h00;
        end else begin
            seq_r <= seq_nxt;
            phase_cnt_r <= phase_cnt_nxt;
        end
    end

    // lane outputs registered straight from their next values
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lane_state <= CLTOV_SEQ_STOP;
            hs_clk_active <= 1'b0;
        end else begin
            lane_state <= seq_nxt;
            hs_clk_active <= (seq_nxt == CLTOV_SEQ_HS);
        end
    end

    // ***************************************************************
    // read path
    // ***************************************************************
    // data stand only in the cycle after the strobe, zero otherwise
    wire logic [7:0] rd_mux;
    assign rd_mux = hit_prepare ? {clk_prepare_override, clk_prepare_value} :
                    hit_zero ? {clk_zero_override, clk_zero_value} :
                    hit_rate ? {5'h00, rate_r} :
                    hit_status ? {6'h00, seq_r} :
                    `CLTOV_UNMAPPED_RDATA;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    property p_prep_auto;
        @(posedge sys_clk) disable iff (!resetn)
        (!clk_prepare_override && !wr_prepare) |=> (clk_prepare_value == $past(auto_prepare_r));
    endproperty
    a_prep_auto: assert property (p_prep_auto) else $error("prepare value not following auto");

    property p_prep_hold;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_prepare_override && !wr_prepare) |=> $stable(clk_prepare_value) && clk_prepare_override;
    endproperty
    a_prep_hold: assert property (p_prep_hold) else $error("overridden prepare value changed");

    property p_zero_auto;
        @(posedge sys_clk) disable iff (!resetn)
        (!clk_zero_override && !wr_zero) |=> (clk_zero_value == $past(auto_zero_r));
    endproperty
    a_zero_auto: assert property (p_zero_auto) else $error("zero value not following auto");

    property p_ro_read;
        @(posedge sys_clk) disable iff (!resetn)
        (reg_rd && hit_zero && !clk_zero_override && $past(!clk_zero_override && !wr_zero))
        |=> (reg_rdata == {1'b0, $past(auto_zero_r, 2)});
    endproperty
    a_ro_read: assert property (p_ro_read) else $error("zero field read not auto value");

    property p_ov_write;
        @(posedge sys_clk) disable iff (!resetn)
        (wr_prepare && reg_wdata[`CLTOV_OVR_BIT]) ##1 (reg_rd && hit_prepare && !wr_prepare)
        |=> (reg_rdata == {1'b1, $past(reg_wdata[`CLTOV_VAL_MSB:0], 2)});
    endproperty
    a_ov_write: assert property (p_ov_write) else $error("override write not read back");

    property p_reset_vals;
        @(posedge sys_clk)
        !resetn |=> (auto_prepare_r == 7'h05) && (auto_zero_r == 7'h1b) && (clk_zero_value == 7'h1b);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset timing values wrong");

    property p_rate_update;
        @(posedge sys_clk) disable iff (!resetn)
        (wr_rate && reg_wdata[2:0] == 3'h0) ##1 (!wr_rate) |=> (auto_prepare_r == PREP_400);
    endproperty
    a_rate_update: assert property (p_rate_update) else $error("auto prepare missed rate change");

    property p_seq_load;
        @(posedge sys_clk) disable iff (!resetn)
        (seq_r == CLTOV_SEQ_STOP && hs_clk_req)
        |=> (seq_r == CLTOV_SEQ_PREPARE) && (phase_cnt_r == $past(load_prepare));
    endproperty
    a_seq_load: assert property (p_seq_load) else $error("prepare phase not loaded");

    property p_seq_zero;
        @(posedge sys_clk) disable iff (!resetn)
        (seq_r == CLTOV_SEQ_PREPARE && phase_done && hs_clk_req)
        |=> (seq_r == CLTOV_SEQ_ZERO) && (phase_cnt_r == $past(load_zero)) && (lane_state == 2'b10);
    endproperty
    a_seq_zero: assert property (p_seq_zero) else $error("zero phase not loaded");

    c_prep_override: cover property (@(posedge sys_clk) disable iff (!resetn)
        wr_prepare && reg_wdata[`CLTOV_OVR_BIT]);
    c_rate_change: cover property (@(posedge sys_clk) disable iff (!resetn)
        wr_rate && reg_wdata[2:0] == 3'h4);
    c_reach_hs: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(hs_clk_active));

endmodule

`default_nettype wire

/* dv/cltov_rx_model.sv */
// Purpose: downstream receiver view of the clock lane, measures prepare and zero phase lengths
// Assumes: lane_state and hs_clk_active are sampled on the sys_clk rising edge
// Notes: lengths restart in stop, so an aborted start never adds to the next one
`default_nettype none

module cltov_rx_model
    import cltov_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [1:0] lane_state,
    input wire logic hs_clk_active,
    output logic [7:0] prep_len,
    output logic [7:0] zero_len,
    output logic hs_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // ***************************************************************
    // phase measurement in byte clocks
    // ***************************************************************
    // one byte clock per sys_clk, so each sampled cycle is one unit
    always_ff @(posedge sys_clk) begin
        if (!resetn || lane_state == CLTOV_SEQ_STOP) begin
            prep_len <= 8'h00;
            zero_len <= 8'h00;
            hs_seen <= 1'b0;
        end else begin
            if (lane_state == CLTOV_SEQ_PREPARE) begin
                prep_len <= prep_len + 8'h01;
            end
            if (lane_state == CLTOV_SEQ_ZERO) begin
                zero_len <= zero_len + 8'h01;
            end
            // receiver only locks once the lane really runs hs
            hs_seen <= (lane_state == CLTOV_SEQ_HS) && hs_clk_active;
        end
    end
endmodule

`default_nettype wire

/* dv/cltov_tb.sv */
// Purpose: self-checking bench for the clock-lane timing override bank
// Assumes: 40 MHz sys_clk, synchronous active-low resetn held 6 cycles at start
// Notes: auto values per rate live in the row table, all rows but the 800 one are handed to the design
`include "cltov_regs.svh"
`default_nettype none

module testbench
    import cltov_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [2:0] rate;
        logic [6:0] prep;
        logic [6:0] zero;
    } cltov_row_t;

    // last row returns the lane to 800 so later cases start from reset values
    localparam cltov_row_t ROWS [5] = '{'{3'h0, 7'h03, 7'h0e}, '{3'h2, 7'h07, 7'h28},
        '{3'h3, 7'h09, 7'h32}, '{3'h4, 7'h09, 7'h36}, '{3'h1, 7'h05, 7'h1b}};

    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic hs_clk_req = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] lane_state;
    logic hs_clk_active;
    logic [6:0] clk_prepare_cycles;
    logic [6:0] clk_zero_cycles;
    logic [7:0] prep_len;
    logic [7:0] zero_len;
    logic hs_seen;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    cltov_top #(.PREP_400(ROWS[0].prep), .ZERO_400(ROWS[0].zero), .PREP_1200(ROWS[1].prep),
        .ZERO_1200(ROWS[1].zero), .PREP_1500(ROWS[2].prep), .ZERO_1500(ROWS[2].zero),
        .PREP_1600(ROWS[3].prep), .ZERO_1600(ROWS[3].zero)) DUT (.sys_clk(sys_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hs_clk_req(hs_clk_req), .lane_state(lane_state), .hs_clk_active(hs_clk_active),
        .clk_prepare_cycles(clk_prepare_cycles), .clk_zero_cycles(clk_zero_cycles));

    cltov_rx_model RX (.sys_clk(sys_clk), .resetn(resetn), .lane_state(lane_state),
        .hs_clk_active(hs_clk_active), .prep_len(prep_len), .zero_len(zero_len), .hs_seen(hs_seen));

    // ***************************************************************
    // compare, bus and closing tasks
    // ***************************************************************
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t register read got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t lane output got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so sample mid-cycle there
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk_reg(reg_rdata, exp);
    endtask

    task automatic chk_lane(input logic [6:0] p, input logic [6:0] z);
        @(negedge sys_clk);
        chk_out({1'b0, clk_prepare_cycles}, {1'b0, p});
        chk_out({1'b0, clk_zero_cycles}, {1'b0, z});
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // hang guard, the whole run needs well under 400 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            give_verdict();
        end
    end

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        repeat (5) @(posedge sys_clk);
        chk_lane(7'h05, 7'h1b);
        // release right after a rising edge, six edges see reset low
        @(posedge sys_clk);
        resetn <= 1'b1;
        rd_chk(`CLTOV_OFS_CLK_PREPARE, 8'h05);
        rd_chk(`CLTOV_OFS_CLK_ZERO, 8'h1b);
        @(negedge sys_clk);
        chk_reg(reg_rdata, 8'h00);
        // every rate code, fields follow the auto value
        foreach (ROWS[i]) begin
            wr_reg(`CLTOV_OFS_RATE_SEL, {5'h00, ROWS[i].rate});
            repeat (3) @(posedge sys_clk);
            rd_chk(`CLTOV_OFS_CLK_PREPARE, {1'b0, ROWS[i].prep});
            rd_chk(`CLTOV_OFS_CLK_ZERO, {1'b0, ROWS[i].zero});
            chk_lane(ROWS[i].prep, ROWS[i].zero);
        end
        // value written with override clear is dropped
        wr_reg(`CLTOV_OFS_CLK_PREPARE, 8'h22);
        repeat (2) @(posedge sys_clk);
        rd_chk(`CLTOV_OFS_CLK_PREPARE, 8'h05);
        // override both, then a rate change must not disturb them
        wr_reg(`CLTOV_OFS_CLK_PREPARE, 8'h82);
        // read straight behind the write, no idle cycle between the strobes
        reg_rd <= 1'b1;
        reg_addr <= `CLTOV_OFS_CLK_PREPARE;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk_reg(reg_rdata, 8'h82);
        wr_reg(`CLTOV_OFS_CLK_ZERO, 8'h83);
        rd_chk(`CLTOV_OFS_CLK_ZERO, 8'h83);
        wr_reg(`CLTOV_OFS_RATE_SEL, 8'h00);
        repeat (3) @(posedge sys_clk);
        rd_chk(`CLTOV_OFS_CLK_PREPARE, 8'h82);
        chk_lane(7'h02, 7'h03);
        // full start-up with overridden phase lengths
        @(posedge sys_clk);
        hs_clk_req <= 1'b1;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk_out(prep_len, 8'h02);
        chk_out(zero_len, 8'h03);
        chk_out({7'h00, hs_seen}, 8'h01);
        rd_chk(`CLTOV_OFS_SEQ_STATUS, 8'h03);
        @(posedge sys_clk);
        hs_clk_req <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk_out({6'h00, lane_state}, 8'h00);
        // clearing override drops the value and resumes the 400 auto value
        wr_reg(`CLTOV_OFS_CLK_PREPARE, 8'h05);
        repeat (2) @(posedge sys_clk);
        rd_chk(`CLTOV_OFS_CLK_PREPARE, 8'h03);
        // abort in the last prepare cycle, the dropped request wins over the move to zero
        @(posedge sys_clk);
        hs_clk_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk_out({6'h00, lane_state}, 8'h01);
        @(posedge sys_clk);
        hs_clk_req <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk_out({6'h00, lane_state}, 8'h00);
        // refused accesses
        wr_reg(`CLTOV_OFS_RATE_SEL, 8'h07);
        rd_chk(`CLTOV_OFS_RATE_SEL, 8'h00);
        wr_reg(`CLTOV_OFS_SEQ_STATUS, 8'hff);
        rd_chk(`CLTOV_OFS_SEQ_STATUS, 8'h00);
        rd_chk(8'h55, 8'h00);
        // second reset in mid-run restores the 800 set
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rd_chk(`CLTOV_OFS_CLK_ZERO, 8'h1b);
        rd_chk(`CLTOV_OFS_RATE_SEL, 8'h01);
        chk_lane(7'h05, 7'h1b);
        give_verdict();
    end
endmodule

`default_nettype wire
